//--- pmc_power_mode_ctrl.sv
// Power-mode sequencer and system clock control with an APB register file.
//
// How it works
// - Normal: core clock and all enabled peripheral clocks run.
// - Idle bit halts core; interrupt resumes it.
// - Suspend/snooze stop core, peripherals, fast oscillators.
// - Timers 3 and 4 may run from slow.
// - Suspend keeps regulator in normal bias.
// - Snooze bit entered; regulator drops to low bias.
// - Six listed events end suspend and snooze.
// - Stop powers nets down; any reset exits.
// - Shutdown exits only on pin or power-on reset.
// - Unused peripheral clocks are gated off.
// - Reset clock: fast oscillator A divided by 8.
// - Source: fast A, fast B, slow, external.
// - Divider by 1 to 128 in powers of two.
// - Fast sources offer a 1.5x prescaler.
//
// Design decisions made here: register access over APB and the address map.
module pmc_power_mode_ctrl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic coreIrq,
    input wire logic timer4Evt,
    input wire logic spiActive,
    input wire logic i2cSlaveActive,
    input wire logic portMatch,
    input wire logic cmp0Out,
    input wire logic cluIrqEvt,
    input wire logic resetPinN,
    input wire logic porReset,
    input wire logic otherResetReq,
    output logic coreClkEn,
    output logic [7:0] periphClkEn,
    output logic timer34OnSlow,
    output logic fastOscAEn,
    output logic fastOscBEn,
    output logic slowOscEn,
    output logic extClkEn,
    output logic regLowBias,
    output logic powerNetsOn,
    output logic pinRetain,
    output logic [1:0] sysClkSrc,
    output logic [2:0] sysClkDiv,
    output logic preScaleEn,
    output logic [2:0] modeState
);
    // ========================================
    // Helpers.

    // True in the two clock-stopped modes that keep their power.
    function automatic logic isLowMode(input pmc_pkg::pmc_mode_e m);
        return (m == pmc_pkg::MODE_SUSPEND) || (m == pmc_pkg::MODE_SNOOZE);
    endfunction : isLowMode

    // True in the two modes that drop all internal power.
    function automatic logic isOffMode(input pmc_pkg::pmc_mode_e m);
        return (m == pmc_pkg::MODE_STOP) || (m == pmc_pkg::MODE_SHUTDOWN);
    endfunction : isOffMode

    // ========================================
    // State.
    pmc_pkg::pmc_mode_e mode_ff; // Current power mode.
    pmc_pkg::pmc_mode_e nxt_mode; // Mode for the next cycle.
    logic idleReq_ff; // Idle request bit.
    logic stopReq_ff; // Stop request bit.
    logic suspendReq_ff; // Suspend request bit.
    logic snoozeReq_ff; // Snooze request bit.
    logic stopDepth_ff; // Stop depth select.
    logic [1:0] clkSrc_ff; // Selected clock source.
    logic [2:0] clkDiv_ff; // Divider exponent.
    logic preScale_ff; // 1.5x prescaler request.
    logic [7:0] periphEn_ff; // Per-peripheral clock enables.
    logic [5:0] wakeCause_ff; // Sources of the last low-mode wake.
    logic cmp0Prev_ff; // Filtered comparator level, one cycle old.
    logic [pmc_pkg::SYNC_N-1:0] syncIn; // Filtered outside inputs.
    logic [5:0] wakeSrc; // Wake sources this cycle.
    logic wakeLow; // Wake from suspend or snooze.
    logic wakeIdle; // Wake from idle.
    logic hardRst; // Pin or power-on reset.
    logic softRst; // Reset source that restores defaults.
    logic apbAccess; // Access phase waiting for ready.
    logic apbDone; // Transfer completes at this edge.
    logic [31:0] rdMux; // Read data for the current address.
    logic addrOk; // Address is mapped.

    // ========================================
    // Input synchronisers for pins and other-domain events.
    pmc_sync3 #(
        .W(pmc_pkg::SYNC_N),
        .RST_VAL(pmc_pkg::SYNC_RST)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .din({otherResetReq, porReset, resetPinN, cluIrqEvt, cmp0Out,
              portMatch, i2cSlaveActive, spiActive, timer4Evt}),
        .dout(syncIn)
    );

    // Comparator history for the falling edge.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmp0Prev_ff <= 1'b0;
        end else begin
            cmp0Prev_ff <= syncIn[pmc_pkg::IN_CMP0];
        end
    end

    // Wake and reset decode.
    always_comb begin
        wakeSrc = syncIn[5:0];
        // Only the comparator's falling edge counts.
        wakeSrc[pmc_pkg::IN_CMP0] = cmp0Prev_ff && !syncIn[pmc_pkg::IN_CMP0];
        wakeLow = isLowMode(mode_ff) && (|wakeSrc);
        wakeIdle = (mode_ff == pmc_pkg::MODE_IDLE) && coreIrq;
        hardRst = !syncIn[pmc_pkg::IN_PIN_N] || syncIn[pmc_pkg::IN_POR];
        // Shutdown ignores every reset but pin and power-on.
        if (mode_ff == pmc_pkg::MODE_SHUTDOWN) begin
            softRst = hardRst;
        end else begin
            softRst = hardRst || syncIn[pmc_pkg::IN_RST];
        end
    end

    // ========================================
    // APB slave: ready comes one cycle into the access phase.
    assign apbAccess = psel && penable && !pready;
    assign apbDone = psel && penable && pready;

    // Read decode; unmapped addresses read zero with an error.
    always_comb begin
        rdMux = 32'h0000_0000;
        addrOk = 1'b1;
        unique case (paddr)
            pmc_pkg::OFS_PWR_A: begin
                rdMux[pmc_pkg::IDLE_BIT] = idleReq_ff;
                rdMux[pmc_pkg::STOP_BIT] = stopReq_ff;
            end
            pmc_pkg::OFS_PWR_B: begin
                rdMux[pmc_pkg::SUSPEND_BIT] = suspendReq_ff;
                rdMux[pmc_pkg::SNOOZE_BIT] = snoozeReq_ff;
            end
            pmc_pkg::OFS_REG_CTL: begin
                rdMux[pmc_pkg::DEPTH_BIT] = stopDepth_ff;
            end
            pmc_pkg::OFS_CLK_SEL: begin
                rdMux[pmc_pkg::SRC_LSB +: 2] = clkSrc_ff;
                rdMux[pmc_pkg::DIV_LSB +: 3] = clkDiv_ff;
                rdMux[pmc_pkg::PRESCALE_BIT] = preScale_ff;
            end
            pmc_pkg::OFS_PCLK_EN: begin
                rdMux[7:0] = periphEn_ff;
            end
            pmc_pkg::OFS_STATUS: begin
                rdMux[2:0] = mode_ff;
                rdMux[pmc_pkg::CAUSE_LSB +: 6] = wakeCause_ff;
            end
            default: begin
                addrOk = 1'b0;
            end
        endcase
    end

    // Bus answer registers.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbAccess;
            pslverr <= apbAccess && !addrOk;
            if (apbAccess && !pwrite) begin
                prdata <= rdMux;
            end
        end
    end

    // ========================================
    // Control registers. A reset source restores defaults; a wake
    // clears the idle request, or both the suspend and snooze requests.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            idleReq_ff <= 1'b0;
            stopReq_ff <= 1'b0;
            suspendReq_ff <= 1'b0;
            snoozeReq_ff <= 1'b0;
            stopDepth_ff <= 1'b0;
            clkSrc_ff <= pmc_pkg::SRC_RST;
            clkDiv_ff <= pmc_pkg::DIV_RST;
            preScale_ff <= 1'b0;
            periphEn_ff <= pmc_pkg::PCLK_RST;
        end else if (softRst) begin
            idleReq_ff <= 1'b0;
            stopReq_ff <= 1'b0;
            suspendReq_ff <= 1'b0;
            snoozeReq_ff <= 1'b0;
            stopDepth_ff <= 1'b0;
            clkSrc_ff <= pmc_pkg::SRC_RST;
            clkDiv_ff <= pmc_pkg::DIV_RST;
            preScale_ff <= 1'b0;
            periphEn_ff <= pmc_pkg::PCLK_RST;
        end else begin
            if (apbDone && pwrite) begin
                unique case (paddr)
                    pmc_pkg::OFS_PWR_A: begin
                        idleReq_ff <= pwdata[pmc_pkg::IDLE_BIT];
                        stopReq_ff <= pwdata[pmc_pkg::STOP_BIT];
                    end
                    pmc_pkg::OFS_PWR_B: begin
                        suspendReq_ff <= pwdata[pmc_pkg::SUSPEND_BIT];
                        snoozeReq_ff <= pwdata[pmc_pkg::SNOOZE_BIT];
                    end
                    pmc_pkg::OFS_REG_CTL: begin
                        stopDepth_ff <= pwdata[pmc_pkg::DEPTH_BIT];
                    end
                    pmc_pkg::OFS_CLK_SEL: begin
                        clkSrc_ff <= pwdata[pmc_pkg::SRC_LSB +: 2];
                        clkDiv_ff <= pwdata[pmc_pkg::DIV_LSB +: 3];
                        preScale_ff <= pwdata[pmc_pkg::PRESCALE_BIT];
                    end
                    pmc_pkg::OFS_PCLK_EN: begin
                        periphEn_ff <= pwdata[7:0];
                    end
                    default: begin
                    end
                endcase
            end
            if (wakeIdle) begin
                idleReq_ff <= 1'b0;
            end
            if (wakeLow) begin
                suspendReq_ff <= 1'b0;
                snoozeReq_ff <= 1'b0;
            end
        end
    end

    // Wake cause capture for firmware to read.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wakeCause_ff <= 6'h00;
        end else if (wakeLow) begin
            wakeCause_ff <= wakeSrc;
        end
    end

    // ========================================
    // Mode sequencer. Stop outranks snooze, then suspend, then idle.
    // Firmware is trusted to have moved to fast oscillator A already.
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            pmc_pkg::MODE_NORMAL: begin
                if (stopReq_ff && stopDepth_ff) begin
                    nxt_mode = pmc_pkg::MODE_SHUTDOWN;
                end else if (stopReq_ff) begin
                    nxt_mode = pmc_pkg::MODE_STOP;
                end else if (snoozeReq_ff) begin
                    nxt_mode = pmc_pkg::MODE_SNOOZE;
                end else if (suspendReq_ff) begin
                    nxt_mode = pmc_pkg::MODE_SUSPEND;
                end else if (idleReq_ff) begin
                    nxt_mode = pmc_pkg::MODE_IDLE;
                end
            end
            pmc_pkg::MODE_IDLE: begin
                if (wakeIdle) begin
                    nxt_mode = pmc_pkg::MODE_NORMAL;
                end
            end
            pmc_pkg::MODE_SUSPEND, pmc_pkg::MODE_SNOOZE: begin
                if (wakeLow) begin
                    nxt_mode = pmc_pkg::MODE_NORMAL;
                end
            end
            pmc_pkg::MODE_STOP, pmc_pkg::MODE_SHUTDOWN: begin
                if (softRst) begin
                    nxt_mode = pmc_pkg::MODE_NORMAL;
                end
            end
            default: begin
                nxt_mode = pmc_pkg::MODE_NORMAL;
            end
        endcase
        // Any active reset source wins over a pending entry.
        if (softRst) begin
            nxt_mode = pmc_pkg::MODE_NORMAL;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_ff <= pmc_pkg::MODE_NORMAL;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ========================================
    // Clock, oscillator and regulator controls, registered from the
    // next mode so they change in the same cycle as the mode itself.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            coreClkEn <= 1'b1;
            periphClkEn <= pmc_pkg::PCLK_RST;
            timer34OnSlow <= 1'b0;
            fastOscAEn <= 1'b1;
            fastOscBEn <= 1'b0;
            slowOscEn <= 1'b0;
            extClkEn <= 1'b0;
            regLowBias <= 1'b0;
            powerNetsOn <= 1'b1;
            pinRetain <= 1'b0;
            modeState <= pmc_pkg::MODE_NORMAL;
        end else begin
            modeState <= nxt_mode;
            // Core runs only in Normal.
            coreClkEn <= (nxt_mode == pmc_pkg::MODE_NORMAL);
            if (isLowMode(nxt_mode)) begin
                // Only timers 3 and 4 keep a clock, from the slow one.
                periphClkEn <= periphEn_ff & pmc_pkg::TIMER34_MASK;
            end else if (isOffMode(nxt_mode)) begin
                periphClkEn <= 8'h00;
            end else begin
                periphClkEn <= periphEn_ff;
            end
            timer34OnSlow <= isLowMode(nxt_mode);
            // Fast oscillators stop in every sleeping mode but Idle.
            fastOscAEn <= !isLowMode(nxt_mode) && !isOffMode(nxt_mode)
                && (clkSrc_ff == pmc_pkg::SRC_FAST_A);
            fastOscBEn <= !isLowMode(nxt_mode) && !isOffMode(nxt_mode)
                && (clkSrc_ff == pmc_pkg::SRC_FAST_B);
            slowOscEn <= !isOffMode(nxt_mode)
                && ((clkSrc_ff == pmc_pkg::SRC_SLOW) || isLowMode(nxt_mode));
            extClkEn <= !isLowMode(nxt_mode) && !isOffMode(nxt_mode)
                && (clkSrc_ff == pmc_pkg::SRC_EXT);
            regLowBias <= (nxt_mode == pmc_pkg::MODE_SNOOZE);
            powerNetsOn <= !isOffMode(nxt_mode);
            pinRetain <= isOffMode(nxt_mode);
        end
    end

    // System clock selection; the prescaler applies to fast sources only.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysClkSrc <= pmc_pkg::SRC_RST;
            sysClkDiv <= pmc_pkg::DIV_RST;
            preScaleEn <= 1'b0;
        end else begin
            sysClkSrc <= clkSrc_ff;
            sysClkDiv <= clkDiv_ff;
            preScaleEn <= preScale_ff
                && ((clkSrc_ff == pmc_pkg::SRC_FAST_A)
                || (clkSrc_ff == pmc_pkg::SRC_FAST_B));
        end
    end

    // ========================================
    // Assertions.
    AST_NORMAL_CLK: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(modeState == pmc_pkg::MODE_NORMAL) |-> coreClkEn)
        else $error("core clock off in normal mode");
    AST_IDLE_WAKE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode_ff == pmc_pkg::MODE_IDLE && coreIrq && !softRst)
        |=> (mode_ff == pmc_pkg::MODE_NORMAL) && !idleReq_ff)
        else $error("idle not left on interrupt");
    AST_IDLE_CLK: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode_ff == pmc_pkg::MODE_IDLE) |-> !coreClkEn
        && periphClkEn == periphEn_ff)
        else $error("idle clocks wrong");
    AST_LOW_OSC: assert property (@(posedge core_clk) disable iff (sys_rst)
        isLowMode(mode_ff) |-> !fastOscAEn && !fastOscBEn
        && !coreClkEn)
        else $error("fast clock running while asleep");
    AST_LOW_TIMER: assert property (@(posedge core_clk) disable iff (sys_rst)
        isLowMode(mode_ff) |-> slowOscEn && timer34OnSlow
        && (periphClkEn & ~pmc_pkg::TIMER34_MASK) == 8'h00)
        else $error("non-timer clock running while asleep");
    AST_BIAS: assert property (@(posedge core_clk) disable iff (sys_rst)
        regLowBias == (mode_ff == pmc_pkg::MODE_SNOOZE))
        else $error("regulator bias does not follow mode");
    AST_LOW_WAKE: assert property (@(posedge core_clk) disable iff (sys_rst)
        wakeLow |=> (mode_ff == pmc_pkg::MODE_NORMAL) && !suspendReq_ff
        && !snoozeReq_ff ##1 coreClkEn)
        else $error("low mode not left on wake");
    AST_STOP_ENTRY: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode_ff == pmc_pkg::MODE_NORMAL && stopReq_ff && !softRst)
        |=> mode_ff == (stopDepth_ff ? pmc_pkg::MODE_SHUTDOWN
        : pmc_pkg::MODE_STOP))
        else $error("stop depth not honoured");
    AST_OFF_NETS: assert property (@(posedge core_clk) disable iff (sys_rst)
        isOffMode(mode_ff) |-> !powerNetsOn && pinRetain)
        else $error("power nets on in stop");
    AST_SHUT_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        (mode_ff == pmc_pkg::MODE_SHUTDOWN && !hardRst)
        |=> mode_ff == pmc_pkg::MODE_SHUTDOWN)
        else $error("shutdown left without pin or power-on reset");
endmodule : pmc_power_mode_ctrl

//--- pmc_pkg.sv
// Package of register map, field layout and mode codes for the power block.
package pmc_pkg;
    // ========================================
    // Register byte offsets on the APB.
    localparam logic [7:0] OFS_PWR_A = 8'h00;
    localparam logic [7:0] OFS_PWR_B = 8'h04;
    localparam logic [7:0] OFS_REG_CTL = 8'h08;
    localparam logic [7:0] OFS_CLK_SEL = 8'h0C;
    localparam logic [7:0] OFS_PCLK_EN = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // ========================================
    // Field positions.
    localparam int IDLE_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int SUSPEND_BIT = 0;
    localparam int SNOOZE_BIT = 1;
    localparam int DEPTH_BIT = 0;
    localparam int SRC_LSB = 0;
    localparam int DIV_LSB = 4;
    localparam int PRESCALE_BIT = 8;
    localparam int CAUSE_LSB = 8;
    // ========================================
    // Clock source codes.
    localparam logic [1:0] SRC_FAST_A = 2'h0;
    localparam logic [1:0] SRC_FAST_B = 2'h1;
    localparam logic [1:0] SRC_SLOW = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    // ========================================
    // Reset values: divide code 3 gives a divide by 8.
    localparam logic [1:0] SRC_RST = SRC_FAST_A;
    localparam logic [2:0] DIV_RST = 3'h3;
    localparam logic [7:0] PCLK_RST = 8'hFF;
    // Peripheral enables kept alive from the slow clock (timers 3 and 4).
    localparam logic [7:0] TIMER34_MASK = 8'h18;
    // Number of wake sources in the low-power modes.
    localparam int WAKE_N = 6;
    // Synchronised input count and their positions.
    localparam int SYNC_N = 9;
    localparam int IN_CMP0 = 4;
    localparam int IN_PIN_N = 6;
    localparam int IN_POR = 7;
    localparam int IN_RST = 8;
    localparam logic [8:0] SYNC_RST = 9'h040;
    // ========================================
    // Power modes.
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_IDLE = 3'b001,
        MODE_SUSPEND = 3'b010,
        MODE_SNOOZE = 3'b011,
        MODE_STOP = 3'b100,
        MODE_SHUTDOWN = 3'b101
    } pmc_mode_e;
endpackage : pmc_pkg

//--- pmc_sync3.sv
// Three-stage input synchroniser with an agreement filter.
module pmc_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // ========================================
    // Stages; the first is read only by the second.
    logic [W-1:0] stg1_ff;
    logic [W-1:0] stg2_ff;
    logic [W-1:0] stg3_ff;

    // The chain shifts on every rising edge.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stg1_ff <= RST_VAL;
            stg2_ff <= RST_VAL;
            stg3_ff <= RST_VAL;
        end else begin
            stg1_ff <= din;
            stg2_ff <= stg1_ff;
            stg3_ff <= stg2_ff;
        end
    end

    // A bit changes only once stages two and three agree, so a glitch
    // shorter than two cycles is not passed on.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stg2_ff[i] == stg3_ff[i]) begin
                    dout[i] <= stg3_ff[i];
                end
            end
        end
    end
endmodule : pmc_sync3

//--- tb_pmc_power_mode_ctrl.sv
// Self-checking testbench for the power mode and clock control block.
module tb_pmc_power_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Stimulus and observed signals.
    logic core_clk = 0, sys_rst = 1;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, coreIrq = 0, resetPinN = 1, porReset = 0;
    logic otherResetReq = 0, coreClkEn, timer34OnSlow, fastOscAEn;
    logic fastOscBEn, slowOscEn, extClkEn, regLowBias, powerNetsOn;
    logic pinRetain, preScaleEn;
    logic [5:0] wakeVec = 6'h00; // Wake lines; bit 4 is a falling edge.
    logic [7:0] periphClkEn, en;
    logic [1:0] sysClkSrc;
    logic [2:0] sysClkDiv, modeState;
    logic [31:0] seed = 32'h0000_7B6C, rd, v;
    logic er;
    logic [3:0] osc; // Oscillator enables, ordered by source code.
    int n_errors = 0, checked = 0;
    pmc_power_mode_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .coreIrq(coreIrq), .timer4Evt(wakeVec[0]),
        .spiActive(wakeVec[1]), .i2cSlaveActive(wakeVec[2]),
        .portMatch(wakeVec[3]), .cmp0Out(~wakeVec[4]),
        .cluIrqEvt(wakeVec[5]), .resetPinN(resetPinN),
        .porReset(porReset), .otherResetReq(otherResetReq),
        .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
        .timer34OnSlow(timer34OnSlow), .fastOscAEn(fastOscAEn),
        .fastOscBEn(fastOscBEn), .slowOscEn(slowOscEn),
        .extClkEn(extClkEn), .regLowBias(regLowBias),
        .powerNetsOn(powerNetsOn), .pinRetain(pinRetain),
        .sysClkSrc(sysClkSrc), .sysClkDiv(sysClkDiv),
        .preScaleEn(preScaleEn), .modeState(modeState));
    // ========================================
    // Clock at 8 ns.
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // Repeatable xorshift source.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Counts one comparison and reports a mismatch.
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : chk
    // One APB transfer; pready and read data are taken at the rising edge
    // that completes the access, and only then is the request released.
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Waits a bounded time for the mode code to reach the given value.
    task automatic waitMode(logic [2:0] m);
        int n;
        n = 0;
        while (modeState !== m && n < 30) begin
            @(posedge core_clk);
            n++;
        end
        chk("modeState", {29'h0, m}, {29'h0, modeState});
        if (modeState !== m) results();
    endtask : waitMode
    // Single place where the run ends.
    task automatic results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // ========================================
    // Main sequence.
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 0;
        @(negedge core_clk);
        chk("coreClkEn", 1, coreClkEn);
        chk("periphClkEn", 8'hFF, periphClkEn);
        chk("clk", 6'h23, {fastOscAEn, sysClkSrc, sysClkDiv});
        apb(0, pmc_pkg::OFS_CLK_SEL, 0);
        chk("clkSel", 32'h0000_0030, rd);
        apb(0, 8'h40, 0);
        chk("slverr", 1, er);
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            v = xs() & 32'h0000_0173;
            if (i < 8) v[6:4] = i[2:0];
            apb(1, pmc_pkg::OFS_CLK_SEL, v);
            // The write lands at the last edge; outputs follow one edge on.
            repeat (2) @(negedge core_clk);
            osc = {extClkEn, slowOscEn, fastOscBEn, fastOscAEn};
            chk("osc", 4'h1 << v[1:0], osc);
            chk("src", v[1:0], sysClkSrc);
            chk("div", v[6:4], sysClkDiv);
            chk("pre", v[8] & ~v[1], preScaleEn);
        end
        $display("test clock select done");
        for (int i = 0; i < 6; i++) begin
            en = 8'(xs());
            apb(1, pmc_pkg::OFS_PCLK_EN, {24'h0, en});
            apb(1, pmc_pkg::OFS_CLK_SEL, 32'h0000_0030);
            apb(1, pmc_pkg::OFS_PWR_B, 1 << (i % 2));
            waitMode(3'(2 + i % 2));
            chk("coreClkEn", 0, coreClkEn);
            chk("fastOsc", 0, {fastOscAEn, fastOscBEn});
            chk("periph", en & 8'h18, periphClkEn);
            chk("slow", 2'b11, {slowOscEn, timer34OnSlow});
            chk("lowBias", i % 2, regLowBias);
            @(posedge core_clk);
            wakeVec <= 6'(1 << i);
            waitMode(pmc_pkg::MODE_NORMAL);
            wakeVec <= 0;
            chk("periph", en, periphClkEn);
            apb(0, pmc_pkg::OFS_PWR_B, 0);
            chk("pwrB", 0, rd);
            apb(0, pmc_pkg::OFS_STATUS, 0);
            chk("cause", 32'h0000_0100 << i, rd);
        end
        $display("test wake done");
        apb(1, pmc_pkg::OFS_PWR_A, 1);
        waitMode(pmc_pkg::MODE_IDLE);
        chk("idle", {1'b0, en}, {coreClkEn, periphClkEn});
        @(posedge core_clk);
        coreIrq <= 1;
        waitMode(pmc_pkg::MODE_NORMAL);
        coreIrq <= 0;
        apb(0, pmc_pkg::OFS_PWR_A, 0);
        chk("pwrA", 0, rd);
        $display("test idle done");
        apb(1, pmc_pkg::OFS_REG_CTL, 0);
        apb(1, pmc_pkg::OFS_PWR_A, 2);
        waitMode(pmc_pkg::MODE_STOP);
        chk("stop", 2'b01, {powerNetsOn, pinRetain});
        otherResetReq <= 1;
        waitMode(pmc_pkg::MODE_NORMAL);
        otherResetReq <= 0;
        // Let the filtered reset fall, or it would swallow the next write.
        repeat (6) @(posedge core_clk);
        apb(1, pmc_pkg::OFS_REG_CTL, 1);
        apb(1, pmc_pkg::OFS_PWR_A, 2);
        waitMode(pmc_pkg::MODE_SHUTDOWN);
        chk("shut", 2'b01, {powerNetsOn, pinRetain});
        otherResetReq <= 1;
        repeat (10) @(posedge core_clk);
        chk("held", pmc_pkg::MODE_SHUTDOWN, modeState);
        porReset <= 1;
        waitMode(pmc_pkg::MODE_NORMAL);
        porReset <= 0;
        otherResetReq <= 0;
        $display("test stop done");
        results();
    end
endmodule : tb_pmc_power_mode_ctrl
